/* rtl/plar_pkg.sv */
// package for the pll lock auto-reset block: register map, field layout, timing
// assumes a single 50 MHz bus clock
package plar_pkg;

    localparam int          CLK_MHZ         = 50;
    localparam int          HOLD_NS         = 1200;
    localparam int          HOLD_CYCLES     = (HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int          CNT_W           = 8;
    localparam logic [7:0]  HOLD_LAST       = 8'(HOLD_CYCLES - 1);

    localparam logic [7:0]  OFS_CTRL        = 8'h00;
    localparam logic [7:0]  OFS_STATUS      = 8'h04;
    localparam logic [7:0]  OFS_IRQ_FLAG    = 8'h08;
    localparam logic [7:0]  OFS_IRQ_MASK    = 8'h0c;

    // ctrl fields
    localparam int          CTRL_AUTO_EN    = 0;
    localparam int          CTRL_SW_RESET   = 1;
    localparam logic [1:0]  CTRL_RESET_VAL  = 2'h1;

    // event flag fields (flag and mask share the layout)
    localparam int          EV_MAJ_LOSS     = 0;
    localparam int          EV_SINGLE_LOSS  = 1;
    localparam int          EV_RELOCK       = 2;
    localparam int          EV_W            = 3;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'h1,
        ST_HOLD   = 4'h2,
        ST_WAIT   = 4'h4,
        ST_LOCKED = 4'h8
    } plar_state_t;

endpackage : plar_pkg

/* rtl/plar_top.sv */
// pll lock auto-reset sequencer with an ahb-lite register slave
// assumes hclk is free running (not from the monitored pll), pins synchronous to hclk
// Summary of operation
// - majority lock falling in operation drives pll reset low at least 1 us, then releases
// - at 50 MHz the reset is held about 1.2 us
// - hold time is a fixed cycle count, so slower clock holds longer
// - user fabric reset request is forwarded to the pll reset
// - user reset request starts the delay counter, never bypasses it
// - pll held in reset while supply-good input is low
// - this logic surrounds every triple-redundant internal-feedback pll
// - lost lock needs a reset toggle; block performs it only while the ctrl auto-enable bit (bit 0) is set
// - majority and three single lock indications are exposed at top level
//
// Our own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module plar_top (
    input  wire logic           hclk,
    input  wire logic           hresetn,
    input  wire logic           hsel,
    input  wire logic [31:0]    haddr,
    input  wire logic [1:0]     htrans,
    input  wire logic           hwrite,
    input  wire logic [2:0]     hsize,
    input  wire logic [31:0]    hwdata,
    input  wire logic           hready,
    output logic      [31:0]    hrdata,
    output logic                hreadyout,
    output logic                hresp,
    input  wire logic           majority_lock,
    input  wire logic [2:0]     single_lock,
    input  wire logic           user_pll_reset_request_n,
    input  wire logic           pll_supply_good,
    output logic                pll_hold_reset_n,
    output logic                majority_lock_out,
    output logic      [2:0]     single_lock_out,
    output logic                irq
);
    import plar_pkg::*;

    typedef struct packed {
        plar_state_t        st;
        logic [CNT_W-1:0]   cnt;
        logic               rst_n;
        logic               lock_d;
        logic [2:0]         slock_d;
        logic               maj_o;
        logic [2:0]         sl_o;
        logic [1:0]         ctrl;
        logic [EV_W-1:0]    flag;
        logic [EV_W-1:0]    mask;
        logic               irq;
        logic               dp_wr;
        logic               dp_rd;
        logic [7:0]         dp_addr;
        logic [31:0]        rdata;
    } plar_regs_t;

    plar_regs_t r_r;
    plar_regs_t r_nxt;

    logic       req;
    logic       fall;
    logic [2:0] sfall;
    logic [EV_W-1:0] ev;

    always_comb begin
        r_nxt = r_r;
        fall  = r_r.lock_d & ~majority_lock;
        sfall = r_r.slock_d & ~single_lock;
        ev    = '0;
        req   = ~user_pll_reset_request_n | r_r.ctrl[CTRL_SW_RESET];
        r_nxt.lock_d  = majority_lock;
        r_nxt.slock_d = single_lock;
        r_nxt.maj_o   = majority_lock;
        r_nxt.sl_o    = single_lock;
        if (|sfall) begin
            ev[EV_SINGLE_LOSS] = 1'b1;
        end
        r_nxt.ctrl[CTRL_SW_RESET] = 1'b0;

        case (r_r.st)
            ST_IDLE: begin
                // waiting for first lock; unlock here is not a loss
                r_nxt.rst_n = 1'b1;
                if (req) begin
                    r_nxt.st    = ST_HOLD;
                    r_nxt.cnt   = '0;
                    r_nxt.rst_n = 1'b0;
                end else if (majority_lock) begin
                    r_nxt.st = ST_LOCKED;
                end
            end
            ST_LOCKED: begin
                r_nxt.rst_n = 1'b1;
                if (req) begin
                    r_nxt.st    = ST_HOLD;
                    r_nxt.cnt   = '0;
                    r_nxt.rst_n = 1'b0;
                end else if (fall && r_r.ctrl[CTRL_AUTO_EN]) begin
                    ev[EV_MAJ_LOSS] = 1'b1;
                    r_nxt.st    = ST_HOLD;
                    r_nxt.cnt   = '0;
                    r_nxt.rst_n = 1'b0;
                end else if (fall) begin
                    ev[EV_MAJ_LOSS] = 1'b1;
                    r_nxt.st = ST_IDLE;
                end
            end
            ST_HOLD: begin
                r_nxt.rst_n = 1'b0;
                if (r_r.cnt == HOLD_LAST) begin
                    if (!req) begin
                        r_nxt.st    = ST_WAIT;
                        r_nxt.rst_n = 1'b1;
                    end
                end else begin
                    r_nxt.cnt = r_r.cnt + 8'h01;
                end
            end
            ST_WAIT: begin
                r_nxt.rst_n = 1'b1;
                if (req) begin
                    r_nxt.st    = ST_HOLD;
                    r_nxt.cnt   = '0;
                    r_nxt.rst_n = 1'b0;
                end else if (majority_lock) begin
                    ev[EV_RELOCK] = 1'b1;
                    r_nxt.st = ST_LOCKED;
                end
            end
            default: begin
                r_nxt.st    = ST_IDLE;
                r_nxt.rst_n = 1'b1;
            end
        endcase

        // supply not good: keep pll in reset and restart the hold afterwards
        if (!pll_supply_good) begin
            r_nxt.st    = ST_HOLD;
            r_nxt.cnt   = '0;
            r_nxt.rst_n = 1'b0;
        end

        // ahb-lite data phase
        r_nxt.dp_wr = 1'b0;
        r_nxt.dp_rd = 1'b0;
        if (r_r.dp_wr) begin
            case (r_r.dp_addr)
                OFS_CTRL:     r_nxt.ctrl = hwdata[1:0];
                OFS_IRQ_FLAG: r_nxt.flag = r_r.flag & ~hwdata[EV_W-1:0];
                OFS_IRQ_MASK: r_nxt.mask = hwdata[EV_W-1:0];
                default: ;
            endcase
        end
        // set wins over a same-cycle clear
        r_nxt.flag = r_nxt.flag | ev;
        r_nxt.irq  = |(r_nxt.flag & r_nxt.mask);

        if (hsel && hready && htrans[1]) begin
            r_nxt.dp_wr   = hwrite;
            r_nxt.dp_rd   = ~hwrite;
            r_nxt.dp_addr = haddr[7:0];
            r_nxt.rdata   = '0;
            if (!hwrite) begin
                case (haddr[7:0])
                    OFS_CTRL:     r_nxt.rdata = {30'h0, r_r.ctrl};
                    OFS_STATUS:   r_nxt.rdata = {20'h0, r_r.st, 3'h0, r_r.rst_n,
                                                 r_r.sl_o, r_r.maj_o};
                    OFS_IRQ_FLAG: r_nxt.rdata = {29'h0, r_r.flag};
                    OFS_IRQ_MASK: r_nxt.rdata = {29'h0, r_r.mask};
                    default:      r_nxt.rdata = '0;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_r         <= '0;
            r_r.st      <= ST_IDLE;
            r_r.rst_n   <= 1'b1;
            r_r.ctrl    <= CTRL_RESET_VAL;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign hrdata            = r_r.rdata;
    assign hreadyout         = 1'b1;
    assign hresp             = 1'b0;
    assign pll_hold_reset_n  = r_r.rst_n;
    assign majority_lock_out = r_r.maj_o;
    assign single_lock_out   = r_r.sl_o;
    assign irq               = r_r.irq;

endmodule : plar_top
`default_nettype wire

/* bench/plar_pll_model.sv */
// triple pll stand-in: locks a while after reset release, stays lost until reset
// assumes rst_n is the pll reset combined with the bench reset
`timescale 1ns/1ns
`default_nettype none
module plar_pll_model #(parameter int LOCK_DLY = 20) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       lose,
    input  wire logic [2:0] drop,
    output logic            maj,
    output logic      [2:0] sgl
);
    logic [7:0] cnt_r;
    logic       lost_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 8'h0;
            lost_r <= 1'b0;
        end else begin
            if (cnt_r < 8'(LOCK_DLY)) cnt_r <= cnt_r + 8'h1;
            if (lose) lost_r <= 1'b1;
        end
    end
    assign maj = (cnt_r == 8'(LOCK_DLY)) && !lost_r;
    assign sgl = {3{maj}} & ~drop;
endmodule : plar_pll_model
`default_nettype wire

/* bench/plar_checker.sv */
// port-level checks on the pll reset sequencer
// assumes one hclk domain with hresetn active low
`timescale 1ns/1ns
`default_nettype none
module plar_checker
    import plar_pkg::*;
(
    input wire logic       hclk, hresetn, hreadyout, hresp, majority_lock,
    input wire logic [2:0] single_lock, single_lock_out,
    input wire logic       user_pll_reset_request_n, pll_supply_good,
    input wire logic       pll_hold_reset_n, majority_lock_out, irq
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [8:0] cnt_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) cnt_r <= 9'h0;
        else if (pll_hold_reset_n) cnt_r <= 9'h0;
        // saturate so a long supply-low hold cannot wrap the count
        else if (cnt_r != 9'h1ff) cnt_r <= cnt_r + 9'h1;
    end
    AST_REQ: assert property (!user_pll_reset_request_n |=> !pll_hold_reset_n)
        else $error("request did not reset pll");
    AST_SUP: assert property (!pll_supply_good |=> !pll_hold_reset_n)
        else $error("supply low did not reset pll");
    AST_HOLD: assert property ($rose(pll_hold_reset_n) |-> cnt_r >= 9'(HOLD_CYCLES))
        else $error("pll reset pulse too short");
    AST_REL: assert property ($rose(pll_hold_reset_n) |->
        $past(user_pll_reset_request_n) && $past(pll_supply_good))
        else $error("pll reset released while held");
    AST_MAJ: assert property ($past(hresetn) |-> majority_lock_out == $past(majority_lock))
        else $error("majority lock copy wrong");
    AST_SGL: assert property ($past(hresetn) |-> single_lock_out == $past(single_lock))
        else $error("single lock copy wrong");
    AST_RDY: assert property (hreadyout)
        else $error("wait state inserted");
    AST_RESP: assert property (!hresp)
        else $error("error response");
    cover property ($fell(majority_lock) ##1 !pll_hold_reset_n);
    cover property ($rose(pll_hold_reset_n));
    cover property ($rose(irq));
endmodule : plar_checker
bind plar_top plar_checker i_chk (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
    .hresp(hresp), .majority_lock(majority_lock), .single_lock(single_lock),
    .single_lock_out(single_lock_out), .user_pll_reset_request_n(user_pll_reset_request_n),
    .pll_supply_good(pll_supply_good), .pll_hold_reset_n(pll_hold_reset_n),
    .majority_lock_out(majority_lock_out), .irq(irq));
`default_nettype wire

/* bench/tb_plar_top.sv */
// register-level test of the pll reset sequencer against a pll stand-in
// assumes zero wait-state slave feeding its own hready
`timescale 1ns/1ns
`default_nettype none
module tb_plar_top;
    import plar_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, lose, irq, mlo;
    logic user_pll_reset_request_n, pll_supply_good, pll_hold_reset_n, mj;
    logic [1:0] htrans;
    logic [2:0] drop, sl, slo;
    logic [31:0] haddr, hwdata, hrdata, r;
    int n_errors, checked, n;
    plar_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .majority_lock(mj),
        .single_lock(sl), .user_pll_reset_request_n(user_pll_reset_request_n),
        .pll_supply_good(pll_supply_good), .pll_hold_reset_n(pll_hold_reset_n),
        .majority_lock_out(mlo), .single_lock_out(slo), .irq(irq));
    plar_pll_model i_pll (.clk(hclk), .rst_n(pll_hold_reset_n && hresetn), .lose(lose),
        .drop(drop), .maj(mj), .sgl(sl));
    task automatic ck(input string s, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s exp %h got %h", s, e, g);
        end
    endtask : ck
    task automatic end_sim;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_sim
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : ahb
    task automatic rd(input logic [7:0] a, input string s, input logic [31:0] e, m);
        ahb(1'b0, a, 32'h0);
        ck(s, e, r & m);
    endtask : rd
    task automatic low_len;
        int w;
        n = 0; w = 0;
        while (pll_hold_reset_n !== 1'b0 && w < 200) begin @(negedge hclk); w++; end
        while (pll_hold_reset_n === 1'b0 && n < 400) begin @(negedge hclk); n++; end
    endtask : low_len
    task automatic kill;
        @(posedge hclk) lose <= 1'b1;
        @(posedge hclk) lose <= 1'b0;
    endtask : kill
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    initial begin
        #100000 n_errors++;
        end_sim();
    end
    initial begin
        {hresetn, hsel, hwrite, lose, htrans, drop, haddr, hwdata} = '0;
        user_pll_reset_request_n = 1'b1; pll_supply_good = 1'b1;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (30) @(posedge hclk);
        rd(OFS_CTRL, "ctrl", 32'(CTRL_RESET_VAL), 32'h3);
        rd(OFS_IRQ_FLAG, "first_lock", 32'h0, 32'h1);
        rd(OFS_STATUS, "locks", 32'hf, 32'hf);
        ahb(1'b1, OFS_IRQ_FLAG, 32'h7);
        ahb(1'b1, OFS_IRQ_MASK, 32'h7);
        rd(OFS_IRQ_MASK, "mask", 32'h7, 32'h7);
        kill();
        low_len(); ck("hold", HOLD_CYCLES, n);
        ck("irq_on", 32'h1, 32'(irq));
        ck("safe_state", 32'h0, 32'(mlo && hresetn));
        repeat (30) @(posedge hclk);
        rd(OFS_IRQ_FLAG, "flags", 32'h7, 32'h7);
        ahb(1'b1, OFS_IRQ_FLAG, 32'h7);
        rd(OFS_IRQ_FLAG, "w1c", 32'h0, 32'h7);
        ck("irq_off", 32'h0, 32'(irq));
        drop <= 3'h2;
        repeat (3) @(posedge hclk);
        ck("single_out", 32'h5, 32'(slo));
        rd(OFS_IRQ_FLAG, "single", 32'h2, 32'h3);
        drop <= 3'h0;
        user_pll_reset_request_n <= 1'b0;
        fork
            low_len();
            begin repeat (HOLD_CYCLES) @(posedge hclk); user_pll_reset_request_n <= 1'b1; end
        join
        ck("user_hold", 32'h1, 32'(n >= HOLD_CYCLES));
        repeat (30) @(posedge hclk);
        rd(OFS_STATUS, "user_relock", 32'h81f, 32'hf1f);
        pll_supply_good <= 1'b0;
        repeat (80) @(posedge hclk);
        ck("supply", 32'h0, 32'(pll_hold_reset_n));
        pll_supply_good <= 1'b1;
        repeat (100) @(posedge hclk);
        ahb(1'b1, OFS_CTRL, 32'h0);
        kill();
        repeat (70) @(negedge hclk);
        ck("no_auto", 32'h1, 32'(pll_hold_reset_n));
        ahb(1'b1, OFS_CTRL, 32'h3);
        low_len(); ck("sw_hold", HOLD_CYCLES, n);
        repeat (30) @(posedge hclk);
        rd(OFS_STATUS, "relock", 32'h1, 32'h1);
        rd(8'h10, "unmapped", 32'h0, 32'hffffffff);
        end_sim();
    end
endmodule : tb_plar_top
`default_nettype wire
